// >>> rtl/adc_conv_ctrl.sv
// Conversion control of the 10-bit converter: registers, start sources, tracking, results.
//
// Contract
// - Temperature sensor select routes sensor to amplifier
// - Converter clock is system clock divided
// - Start source chosen by two mode bits
// - Busy stays high throughout each conversion
// - Busy falling at conversion end sets done flag, interrupt
// - Result left or right justified per bit
// - Default mode tracks whenever not converting
// - Low-power mode tracks three converter clocks first
// - External start low-power: track while pin low
// - Tracking stops during chip standby
// - Pair configuration upper nibble reads zero
// - Analog part runs only while enabled
// - Reset leaves every input single-ended
`timescale 1ns/1ps
`default_nettype none
module adc_conv_ctrl (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       sfr_wr_i,
  output logic [7:0]      sfr_rdata_o,
  input  wire logic       timer2_ovf_i,
  input  wire logic       timer3_ovf_i,
  input  wire logic       ext_conv_start_i,
  input  wire logic       chip_standby_i,
  input  wire logic       conv_irq_en_i,
  input  wire logic       cmp_i,
  output logic            conv_irq_o,
  output logic            analog_en_o,
  output logic            track_o,
  output logic            temp_sel_o,
  output logic [3:0]      mux_addr_o,
  output logic [3:0]      pair_diff_o,
  output logic [2:0]      gain_o,
  output logic [9:0]      sar_trial_o
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [3:0]           pair_cfg;
    logic [3:0]           chan_addr;
    logic [4:0]           clk_div;
    logic [2:0]           gain;
    logic                 en;
    logic                 tm;
    logic                 done;
    logic                 busy;
    logic [1:0]           cm;
    logic                 wint;
    logic                 ljst;
    logic [7:0]           res_hi;
    logic [7:0]           res_lo;
    logic [7:0]           rdata;
    logic                 ext_s1;
    logic                 ext_s2;
    logic                 ext_prev;
    adc_ctrl_pkg::phase_t phase;
    logic [1:0]           trk_cnt;
    logic                 sar_start;
    logic                 diff_cur;
    logic                 irq;
    logic                 track;
    logic                 aen;
    logic                 temp_sel;
  } ctl_state_t;

  ctl_state_t st_ff;
  ctl_state_t nxt_st;

  logic       sar_tick;
  logic       eng_done;
  logic [9:0] eng_code;
  logic       wr_ctrl;
  logic       ext_rise;
  logic       start_req;
  logic [9:0] res_code;

  // ==========================================================================
  // Converter clock and sequencer
  // ==========================================================================
  conv_clk_div u_div (
    .clk_i      (clk_i),
    .sys_rst_i  (sys_rst_i),
    .div_i      (st_ff.clk_div),
    .sar_tick_o (sar_tick)
  );

  sar_engine u_sar (
    .clk_i      (clk_i),
    .sys_rst_i  (sys_rst_i),
    .start_i    (st_ff.sar_start),
    .sar_tick_i (sar_tick),
    .cmp_i      (cmp_i),
    .trial_o    (sar_trial_o),
    .code_o     (eng_code),
    .done_o     (eng_done)
  );

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    nxt_st   = st_ff;
    wr_ctrl  = sfr_wr_i && sfr_addr_i == adc_ctrl_pkg::OFS_CTRL;
    ext_rise = st_ff.ext_s2 && !st_ff.ext_prev;
    start_req = 1'b0;
    res_code = eng_code;

    nxt_st.ext_s1    = ext_conv_start_i;
    nxt_st.ext_s2    = st_ff.ext_s1;
    nxt_st.ext_prev  = st_ff.ext_s2;
    nxt_st.sar_start = 1'b0;

    // Register writes; the busy bit is not stored from the bus
    if (sfr_wr_i) begin
      case (sfr_addr_i)
        adc_ctrl_pkg::OFS_PAIR_CFG: nxt_st.pair_cfg = sfr_wdata_i[3:0];
        adc_ctrl_pkg::OFS_CHAN_SEL: nxt_st.chan_addr = sfr_wdata_i[3:0];
        adc_ctrl_pkg::OFS_CONF: begin
          nxt_st.clk_div = sfr_wdata_i[7:adc_ctrl_pkg::CONF_DIV_LSB];
          nxt_st.gain    = sfr_wdata_i[adc_ctrl_pkg::CONF_GAIN_MSB:0];
        end
        adc_ctrl_pkg::OFS_CTRL: begin
          nxt_st.en   = sfr_wdata_i[adc_ctrl_pkg::CTRL_EN];
          nxt_st.tm   = sfr_wdata_i[adc_ctrl_pkg::CTRL_TM];
          nxt_st.done = sfr_wdata_i[adc_ctrl_pkg::CTRL_DONE];
          nxt_st.cm   = sfr_wdata_i[adc_ctrl_pkg::CTRL_CM_HI:adc_ctrl_pkg::CTRL_CM_LO];
          nxt_st.wint = sfr_wdata_i[adc_ctrl_pkg::CTRL_WINT];
          nxt_st.ljst = sfr_wdata_i[adc_ctrl_pkg::CTRL_LJST];
        end
        default: ;
      endcase
    end

    // Start source uses the mode in force before this cycle's write
    case (st_ff.cm)
      adc_ctrl_pkg::START_SW:     start_req = wr_ctrl && sfr_wdata_i[adc_ctrl_pkg::CTRL_BUSY];
      adc_ctrl_pkg::START_TIMER3: start_req = timer3_ovf_i;
      adc_ctrl_pkg::START_EXT:    start_req = ext_rise;
      adc_ctrl_pkg::START_TIMER2: start_req = timer2_ovf_i;
      default:                    start_req = 1'b0;
    endcase

    case (st_ff.phase)
      adc_ctrl_pkg::PH_IDLE: begin
        if (st_ff.en && start_req) begin
          nxt_st.busy     = 1'b1;
          nxt_st.diff_cur = !st_ff.chan_addr[3] && st_ff.pair_cfg[st_ff.chan_addr[2:1]];
          nxt_st.trk_cnt  = 2'h0;
          // The pin's low time already served as tracking in that mode
          if (st_ff.tm && st_ff.cm != adc_ctrl_pkg::START_EXT) begin
            nxt_st.phase = adc_ctrl_pkg::PH_TRACK;
          end else begin
            nxt_st.phase     = adc_ctrl_pkg::PH_CONV;
            nxt_st.sar_start = 1'b1;
          end
        end
      end
      adc_ctrl_pkg::PH_TRACK: begin
        if (sar_tick) begin
          if (st_ff.trk_cnt == adc_ctrl_pkg::LP_TRACK_TICKS - 2'h1) begin
            nxt_st.phase     = adc_ctrl_pkg::PH_CONV;
            nxt_st.sar_start = 1'b1;
          end else begin
            nxt_st.trk_cnt = st_ff.trk_cnt + 2'h1;
          end
        end
      end
      adc_ctrl_pkg::PH_CONV: begin
        if (eng_done) begin
          nxt_st.phase = adc_ctrl_pkg::PH_IDLE;
          nxt_st.busy  = 1'b0;
          nxt_st.done  = 1'b1;
          if (st_ff.diff_cur) begin
            res_code[9] = ~eng_code[9];
          end
          if (st_ff.ljst) begin
            nxt_st.res_hi = res_code[9:2];
            nxt_st.res_lo = {res_code[1:0], 6'h00};
          end else begin
            nxt_st.res_hi = {{6{res_code[9] & st_ff.diff_cur}}, res_code[9:8]};
            nxt_st.res_lo = res_code[7:0];
          end
        end
      end
      default: nxt_st.phase = adc_ctrl_pkg::PH_IDLE;
    endcase

    // Disabling aborts quietly: no result and no completion flag
    if (!nxt_st.en) begin
      nxt_st.phase = adc_ctrl_pkg::PH_IDLE;
      nxt_st.busy  = 1'b0;
    end

    nxt_st.aen      = nxt_st.en;
    nxt_st.temp_sel = nxt_st.chan_addr[3];
    nxt_st.irq      = nxt_st.done && conv_irq_en_i;
    if (!nxt_st.en || chip_standby_i) begin
      nxt_st.track = 1'b0;
    end else if (!nxt_st.tm) begin
      nxt_st.track = nxt_st.phase == adc_ctrl_pkg::PH_IDLE;
    end else if (nxt_st.cm == adc_ctrl_pkg::START_EXT) begin
      nxt_st.track = nxt_st.phase == adc_ctrl_pkg::PH_IDLE && !st_ff.ext_s2;
    end else begin
      nxt_st.track = nxt_st.phase == adc_ctrl_pkg::PH_TRACK;
    end

    // Reads have no side effects; data shows one cycle after the address
    case (sfr_addr_i)
      adc_ctrl_pkg::OFS_PAIR_CFG: nxt_st.rdata = {4'h0, st_ff.pair_cfg};
      adc_ctrl_pkg::OFS_CHAN_SEL: nxt_st.rdata = {4'h0, st_ff.chan_addr};
      adc_ctrl_pkg::OFS_CONF:     nxt_st.rdata = {st_ff.clk_div, st_ff.gain};
      adc_ctrl_pkg::OFS_CTRL:     nxt_st.rdata = {st_ff.en, st_ff.tm, st_ff.done, st_ff.busy,
                                                  st_ff.cm, st_ff.wint, st_ff.ljst};
      adc_ctrl_pkg::OFS_RES_HIGH: nxt_st.rdata = st_ff.res_hi;
      adc_ctrl_pkg::OFS_RES_LOW:  nxt_st.rdata = st_ff.res_lo;
      default:                    nxt_st.rdata = 8'h00;
    endcase
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_ff           <= '0;
      st_ff.pair_cfg  <= adc_ctrl_pkg::RST_PAIR_CFG;
      st_ff.chan_addr <= adc_ctrl_pkg::RST_CHAN_SEL;
      st_ff.clk_div   <= adc_ctrl_pkg::RST_CLK_DIV;
      st_ff.gain      <= adc_ctrl_pkg::RST_GAIN;
      st_ff.phase     <= adc_ctrl_pkg::PH_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sfr_rdata_o = st_ff.rdata;
  assign conv_irq_o  = st_ff.irq;
  assign analog_en_o = st_ff.aen;
  assign track_o     = st_ff.track;
  assign temp_sel_o  = st_ff.temp_sel;
  assign mux_addr_o  = st_ff.chan_addr;
  assign pair_diff_o = st_ff.pair_cfg;
  assign gain_o      = st_ff.gain;

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_pair_upper_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sfr_addr_i == adc_ctrl_pkg::OFS_PAIR_CFG |=> sfr_rdata_o[7:4] == 4'h0)
    else $error("pair configuration upper bits not zero");

  a_start_sets_busy: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (st_ff.phase == adc_ctrl_pkg::PH_IDLE && st_ff.en && start_req
      && (!wr_ctrl || sfr_wdata_i[adc_ctrl_pkg::CTRL_EN])) |=> st_ff.busy)
    else $error("accepted start did not raise busy");

  a_done_on_fall: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (st_ff.phase == adc_ctrl_pkg::PH_CONV && eng_done && st_ff.en && !wr_ctrl)
      |=> $fell(st_ff.busy) && st_ff.done ##1 (conv_irq_o == $past(conv_irq_en_i)))
    else $error("busy fall did not set completion flag");

  a_lp_track_len: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (st_ff.phase == adc_ctrl_pkg::PH_TRACK && sar_tick && st_ff.trk_cnt == 2'h2 && st_ff.en && !wr_ctrl)
      |=> st_ff.phase == adc_ctrl_pkg::PH_CONV && st_ff.sar_start)
    else $error("low-power tracking period length wrong");

  a_idle_tracks: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (st_ff.en && !st_ff.tm && st_ff.phase == adc_ctrl_pkg::PH_IDLE && !start_req
      && !chip_standby_i && !sfr_wr_i) |=> track_o)
    else $error("default mode not tracking while idle");

  a_ext_lp_track: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (st_ff.en && st_ff.tm && st_ff.cm == adc_ctrl_pkg::START_EXT && st_ff.ext_s2
      && st_ff.phase == adc_ctrl_pkg::PH_IDLE && !sfr_wr_i) |=> !track_o)
    else $error("tracking while external start pin high");

  a_standby_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    chip_standby_i |=> !track_o)
    else $error("tracking during standby");

  a_shutdown: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!st_ff.en && !sfr_wr_i) |=> !analog_en_o && !track_o && !st_ff.busy)
    else $error("analog part active while disabled");

  a_temp_route: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (st_ff.chan_addr[3] && !sfr_wr_i) |=> temp_sel_o ##1 temp_sel_o || $past(sfr_wr_i))
    else $error("temperature sensor not routed");

  a_diff_sign: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (st_ff.phase == adc_ctrl_pkg::PH_CONV && eng_done && st_ff.diff_cur && st_ff.ljst && st_ff.en)
      |=> st_ff.res_hi[7] == !$past(eng_code[9]))
    else $error("differential result sign not inverted");

endmodule // adc_conv_ctrl
`default_nettype wire

// >>> common/adc_ctrl_pkg.sv
// Package with register map, field layout, reset values and timing counts of the converter control.
package adc_ctrl_pkg;

  // ==========================================================================
  // Register offsets on the special function register port
  // ==========================================================================
  localparam logic [7:0] OFS_PAIR_CFG = 8'hba;
  localparam logic [7:0] OFS_CHAN_SEL = 8'hbb;
  localparam logic [7:0] OFS_CONF     = 8'hbc;
  localparam logic [7:0] OFS_RES_LOW  = 8'hbe;
  localparam logic [7:0] OFS_RES_HIGH = 8'hbf;
  localparam logic [7:0] OFS_CTRL     = 8'he8;

  // ==========================================================================
  // Control register bit positions
  // ==========================================================================
  localparam int CTRL_EN    = 7;
  localparam int CTRL_TM    = 6;
  localparam int CTRL_DONE  = 5;
  localparam int CTRL_BUSY  = 4;
  localparam int CTRL_CM_HI = 3;
  localparam int CTRL_CM_LO = 2;
  localparam int CTRL_WINT  = 1;
  localparam int CTRL_LJST  = 0;

  // Configuration register: divider in bits 7:3, gain in bits 2:0
  localparam int CONF_DIV_LSB  = 3;
  localparam int CONF_GAIN_MSB = 2;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [3:0] RST_PAIR_CFG = 4'h0;
  localparam logic [3:0] RST_CHAN_SEL = 4'h0;
  localparam logic [4:0] RST_CLK_DIV  = 5'h1f;
  localparam logic [2:0] RST_GAIN     = 3'h0;

  // ==========================================================================
  // Start sources, conversion phases and timing
  // ==========================================================================
  localparam logic [1:0] START_SW     = 2'h0;
  localparam logic [1:0] START_TIMER3 = 2'h1;
  localparam logic [1:0] START_EXT    = 2'h2;
  localparam logic [1:0] START_TIMER2 = 2'h3;

  typedef enum logic [1:0] {PH_IDLE, PH_TRACK, PH_CONV} phase_t;

  localparam int         RES_BITS        = 10;
  localparam logic [1:0] LP_TRACK_TICKS  = 2'h3;
  localparam logic [3:0] SAR_MSB_IDX     = 4'h9;
  localparam logic [9:0] SAR_FIRST_TRIAL = 10'h200;

endpackage

// >>> rtl/conv_clk_div.sv
// Converter clock divider: one-cycle tick every (divider field + 1) system clocks.
`timescale 1ns/1ps
`default_nettype none
module conv_clk_div (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [4:0] div_i,
  output logic            sar_tick_o
);

  typedef struct packed {
    logic [4:0] cnt;
    logic       tick;
  } div_state_t;

  div_state_t st_ff;
  div_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    // A field of zero still gives a tick every cycle rather than stalling
    if (st_ff.cnt >= div_i) begin
      nxt_st.cnt  = 5'h00;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt  = st_ff.cnt + 5'h01;
      nxt_st.tick = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sar_tick_o = st_ff.tick;

  // The field must hold over the whole period, or a rewrite would stretch or shorten it legally
  a_tick_spacing: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (st_ff.tick && div_i == 5'h02) ##1 (div_i == 5'h02) ##1 (div_i == 5'h02)
      |-> !$past(st_ff.tick) && !st_ff.tick ##1 st_ff.tick)
    else $error("converter clock tick spacing wrong");

endmodule // conv_clk_div
`default_nettype wire

// >>> rtl/sar_engine.sv
// Successive-approximation sequencer: one result bit per converter clock tick.
`timescale 1ns/1ps
`default_nettype none
module sar_engine (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       start_i,
  input  wire logic       sar_tick_i,
  input  wire logic       cmp_i,
  output logic [9:0]      trial_o,
  output logic [9:0]      code_o,
  output logic            done_o
);

  typedef struct packed {
    logic       cmp_s1;
    logic       cmp_s2;
    logic       busy;
    logic       armed;
    logic [3:0] idx;
    logic [9:0] trial;
    logic [9:0] code;
    logic       done;
  } sar_state_t;

  sar_state_t st_ff;
  sar_state_t nxt_st;
  logic [9:0] bit_mask;

  // The comparator is resynchronised, so the divider must leave at least
  // three system clocks per tick for the decision to be current.
  always_comb begin
    nxt_st        = st_ff;
    bit_mask      = 10'h001 << st_ff.idx;
    nxt_st.cmp_s1 = cmp_i;
    nxt_st.cmp_s2 = st_ff.cmp_s1;
    nxt_st.done   = 1'b0;
    if (start_i) begin
      nxt_st.busy  = 1'b1;
      nxt_st.armed = 1'b0;
      nxt_st.idx   = adc_ctrl_pkg::SAR_MSB_IDX;
      nxt_st.trial = adc_ctrl_pkg::SAR_FIRST_TRIAL;
    end else if (st_ff.busy && sar_tick_i && !st_ff.armed) begin
      // The free-running divider may tick right after the start; that tick
      // only lets the comparator settle on the first trial
      nxt_st.armed = 1'b1;
    end else if (st_ff.busy && sar_tick_i) begin
      if (!st_ff.cmp_s2) begin
        nxt_st.trial = st_ff.trial & ~bit_mask;
      end
      if (st_ff.idx == 4'h0) begin
        nxt_st.busy = 1'b0;
        nxt_st.done = 1'b1;
        nxt_st.code = st_ff.cmp_s2 ? st_ff.trial : (st_ff.trial & ~bit_mask);
      end else begin
        nxt_st.idx   = st_ff.idx - 4'h1;
        nxt_st.trial = nxt_st.trial | (bit_mask >> 1);
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign trial_o = st_ff.trial;
  assign code_o  = st_ff.code;
  assign done_o  = st_ff.done;

  a_done_ends_busy: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st_ff.done |-> !st_ff.busy && $past(st_ff.busy) && $past(st_ff.idx) == 4'h0)
    else $error("sequencer done without finishing last bit");

endmodule // sar_engine
`default_nettype wire

// >>> test/analog_src_model.sv
// Behavioural analog front end: comparator answer for the current trial code.
`timescale 1ns/1ps
`default_nettype none
module analog_src_model (
  input  wire logic       clk_i,
  input  wire logic [9:0] level_i,
  input  wire logic [9:0] trial_i,
  output logic            cmp_o
);
  // Answer settles half a clock after the trial code moves
  always @(negedge clk_i) begin
    cmp_o <= (level_i >= trial_i);
  end
endmodule // analog_src_model
`default_nettype wire

// >>> test/adc_conv_ctrl_tb.sv
// Self-checking testbench of the converter control block.
`timescale 1ns/1ps
`default_nettype none
module adc_conv_ctrl_tb;
  // ======================================
  // Signals
  // ======================================
  logic       clk_i            = 1'b0;
  logic       sys_rst_i        = 1'b1;
  logic [7:0] sfr_addr_i       = 8'h00;
  logic [7:0] sfr_wdata_i      = 8'h00;
  logic       sfr_wr_i         = 1'b0;
  logic       timer2_ovf_i     = 1'b0;
  logic       timer3_ovf_i     = 1'b0;
  logic       ext_conv_start_i = 1'b0;
  logic       chip_standby_i   = 1'b0;
  logic       conv_irq_en_i    = 1'b1;
  logic       cmp_i;
  logic [7:0] sfr_rdata_o;
  logic       conv_irq_o;
  logic       analog_en_o;
  logic       track_o;
  logic       temp_sel_o;
  logic [3:0] mux_addr_o;
  logic [3:0] pair_diff_o;
  logic [2:0] gain_o;
  logic [9:0] sar_trial_o;
  logic [9:0] level            = 10'h000;
  int         err_count        = 0;
  int         n_tests          = 0;
  int         cycles           = 0;
  int         trk_cnt          = 0;
  int         div              = 31;
  int         last_start       = 0;

  adc_conv_ctrl i_adc_conv_ctrl (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_wr_i(sfr_wr_i), .sfr_rdata_o(sfr_rdata_o), .timer2_ovf_i(timer2_ovf_i),
    .timer3_ovf_i(timer3_ovf_i), .ext_conv_start_i(ext_conv_start_i), .chip_standby_i(chip_standby_i),
    .conv_irq_en_i(conv_irq_en_i), .cmp_i(cmp_i), .conv_irq_o(conv_irq_o), .analog_en_o(analog_en_o),
    .track_o(track_o), .temp_sel_o(temp_sel_o), .mux_addr_o(mux_addr_o), .pair_diff_o(pair_diff_o),
    .gain_o(gain_o), .sar_trial_o(sar_trial_o)
  );

  analog_src_model i_analog_src_model (
    .clk_i(clk_i), .level_i(level), .trial_i(sar_trial_o), .cmp_o(cmp_i)
  );

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  // Starts are spaced 1250 cycles apart; the ceiling leaves ample margin
  always @(posedge clk_i) begin
    cycles++;
    if (track_o === 1'b1) trk_cnt++;
    if (cycles == 30000) begin
      err_count++;
      $display("MISMATCH timeout expected finished seen hang");
      finish_test();
    end
  end

  // ======================================
  // Helpers
  // ======================================
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected 0x%h seen 0x%h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    sfr_addr_i  <= a;
    sfr_wdata_i <= d;
    sfr_wr_i    <= 1'b1;
    @(posedge clk_i);
    sfr_wr_i    <= 1'b0;
  endtask

  // Read data is registered on the same edge that samples the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    sfr_addr_i <= a;
    tick(2);
    d = sfr_rdata_o;
  endtask

  // One conversion: clear flag, arm mode, fire the chosen source, poll, read
  task automatic conv(input logic [7:0] ctl, input logic [9:0] lvl, input logic diff);
    logic [7:0] d;
    logic [9:0] c;
    logic [7:0] hi;
    logic [7:0] lo;
    int         n;
    c  = diff ? (lvl ^ 10'h200) : lvl;
    hi = ctl[0] ? c[9:2] : {{6{diff & c[9]}}, c[9:8]};
    lo = ctl[0] ? {c[1:0], 6'h00} : c[7:0];
    level <= lvl;
    wr(8'he8, ctl);
    tick(1);
    check("track idle", !ctl[6] || ctl[3:2] == 2'h2, track_o);
    // Space starts so the converter never runs above 100 ksps
    while (cycles - last_start < 1250) @(posedge clk_i);
    last_start = cycles;
    trk_cnt = 0;
    @(posedge clk_i);
    case (ctl[3:2])
      2'h0: wr(8'he8, ctl | 8'h10);
      2'h1: timer3_ovf_i <= 1'b1;
      2'h2: ext_conv_start_i <= 1'b1;
      default: timer2_ovf_i <= 1'b1;
    endcase
    @(posedge clk_i);
    timer3_ovf_i <= 1'b0;
    timer2_ovf_i <= 1'b0;
    tick(4);
    rd(8'he8, d);
    check("busy during", 1'b1, d[4]);
    if (!ctl[6]) check("track during", 1'b0, track_o);
    n = 0;
    while (d[5] !== 1'b1 && n < 400) begin
      rd(8'he8, d);
      n++;
    end
    check("done flag", 1'b1, d[5]);
    check("busy after", 1'b0, d[4]);
    check("irq", 1'b1, conv_irq_o);
    check("track after", !ctl[6], track_o);
    check("slow enough", 1'b1, (n + 2) * 3 >= 10 * (div + 1));
    if (ctl[6] && ctl[3:2] == 2'h0) begin
      check("lp track", 1'b1, trk_cnt >= 2 * (div + 1) && trk_cnt <= 3 * (div + 1) + 1);
    end
    rd(8'hbf, d);
    check("result high", hi, d);
    rd(8'hbe, d);
    check("result low", lo, d);
    @(posedge clk_i);
    ext_conv_start_i <= 1'b0;
  endtask

  // ======================================
  // Scenarios
  // ======================================
  task automatic s_reset();
    logic [7:0] d;
    rd(8'hba, d);
    check("pair cfg reset", 8'h00, d);
    rd(8'hbc, d);
    check("config reset", 8'hf8, d);
    rd(8'he8, d);
    check("control reset", 8'h00, d);
    rd(8'h55, d);
    check("unmapped", 8'h00, d);
    check("pair out reset", 4'h0, pair_diff_o);
  endtask

  task automatic s_regs();
    logic [7:0] d;
    wr(8'hba, 8'hf5);
    rd(8'hba, d);
    check("pair cfg", 8'h05, d);
    check("pair out", 4'h5, pair_diff_o);
    wr(8'hbb, 8'h08);
    tick(2);
    check("temp sel", 1'b1, temp_sel_o);
    wr(8'hbb, 8'hf3);
    wr(8'hbc, 8'h13);
    tick(2);
    check("mux addr", 4'h3, mux_addr_o);
    check("temp off", 1'b0, temp_sel_o);
    check("gain", 3'h3, gain_o);
  endtask

  task automatic s_convs();
    div = 2;
    wr(8'hba, 8'h00);
    wr(8'hbb, 8'h00);
    conv(8'h80, 10'h2a5, 1'b0);
    conv(8'h81, 10'h16b, 1'b0);
    conv(8'h84, 10'h3ff, 1'b0);
    conv(8'h88, 10'h000, 1'b0);
    conv(8'h8c, 10'h155, 1'b0);
    wr(8'hbc, 8'h10);
    conv(8'hc0, 10'h0f0, 1'b0);
    conv(8'hc8, 10'h301, 1'b0);
    wr(8'hba, 8'h01);
    conv(8'h80, 10'h0c3, 1'b1);
    conv(8'h81, 10'h3a0, 1'b1);
    wr(8'hba, 8'h00);
    div = 6;
    wr(8'hbc, 8'h30);
    conv(8'h80, 10'h1e7, 1'b0);
    @(posedge clk_i);
    conv_irq_en_i <= 1'b0;
    tick(2);
    check("irq masked", 1'b0, conv_irq_o);
  endtask

  task automatic s_power();
    logic [7:0] d;
    wr(8'he8, 8'h80);
    tick(2);
    check("analog on", 1'b1, analog_en_o);
    check("track on", 1'b1, track_o);
    @(posedge clk_i);
    chip_standby_i <= 1'b1;
    tick(2);
    check("standby track", 1'b0, track_o);
    @(posedge clk_i);
    chip_standby_i <= 1'b0;
    wr(8'he8, 8'h00);
    wr(8'he8, 8'h10);
    rd(8'he8, d);
    check("busy disabled", 1'b0, d[4]);
    check("analog off", 1'b0, analog_en_o);
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    s_reset();
    s_regs();
    s_convs();
    s_power();
    finish_test();
  end
endmodule // adc_conv_ctrl_tb
`default_nettype wire
